/* File: cie_alu.sv */
// Arithmetic and logic unit for the executed instruction subset.
// Assumes operands are stable for the process phase.
`timescale 1ns/1ps
module cie_alu (
  // Operation and operands
  input  wire cie_pkg::cie_op_t    op,
  input  wire logic [7:0]          accVal,
  input  wire logic [7:0]          fileVal,
  input  wire logic                carryIn,
  input  wire logic [2:0]          bitSel,
  input  wire logic [7:0]          literal,
  // Results
  output cie_pkg::cie_flags_t      flags,
  output cie_pkg::cie_flags_t      upd,
  output logic [7:0]               result
);
  import cie_pkg::*;

  logic [7:0] opA;
  logic [7:0] opB;
  logic       cin;
  logic [4:0] low;
  logic [8:0] sum;

  always_comb begin
    opA    = fileVal;
    opB    = 8'h00;
    cin    = 1'b0;
    upd    = '0;
    result = fileVal;
    unique case (op)
      // RULE3 add with carry
      OP_ADDC: begin opB = accVal; cin = carryIn; upd = '1; end
      // RULE8 increment file
      OP_INCREMENT_FILE_OP: begin cin = 1'b1; upd = '1; end
      // RULE9 subtract with borrow
      OP_SUBB: begin opB = ~accVal; cin = carryIn; upd = '1; end
      // RULE4 only n and z
      OP_ANDL: begin upd.n = 1'b1; upd.z = 1'b1; end
      default: ;
    endcase
    low = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
    sum = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
    unique case (op)
      OP_ADDC, OP_INCREMENT_FILE_OP, OP_SUBB: result = sum[7:0];
      // RULE4 and with literal
      OP_ANDL: result = accVal & literal;
      // RULE5 invert one bit
      OP_TOGL: result = fileVal ^ (8'h01 << bitSel);
      // RULE10 exchange nibbles
      OP_SWAP: result = {fileVal[3:0], fileVal[7:4]};
      default: result = fileVal;
    endcase
    flags.n  = result[7];
    flags.z  = (result == 8'h00);
    flags.dc = low[4];
    flags.c  = sum[8];
    flags.ov = (opA[7] == opB[7]) && (result[7] != opA[7]);
  end

endmodule

/* File: cie_cfg.svh */
// Constants for the instruction execute block: register offsets, reset
// values, opcode prefixes and access bank layout.
// Assumes inclusion by its bare name from the core, the checker and the testbench.
`ifndef CIE_CFG_SVH
`define CIE_CFG_SVH

// Register byte offsets (AHB-Lite, one word each)
`define CIE_OFS_CTRL   12'h000
`define CIE_OFS_STATUS 12'h004
`define CIE_OFS_ACC    12'h008
`define CIE_OFS_BANK   12'h00c
`define CIE_OFS_PC     12'h010
`define CIE_OFS_INSTR  12'h014

// Reset values
`define CIE_RST_CTRL   1'h0
`define CIE_RST_ACC    8'h00
`define CIE_RST_BANK   4'h0
`define CIE_RST_PC     21'h000000
`define CIE_RST_FLAGS  5'h00

// Opcode prefixes
`define CIE_OPC_ADDC   6'h08
`define CIE_OPC_ANDL   8'h0b
`define CIE_OPC_TOGL   4'h7
`define CIE_OPC_BOV    8'he4
`define CIE_OPC_JMP1   8'hef
`define CIE_OPC_JMP2   4'hf
`define CIE_OPC_INCREMENT_FILE_OP   6'h0a
`define CIE_OPC_SUBB   6'h16
`define CIE_OPC_SWAP   6'h0e

// Instruction field positions
`define CIE_BIT_DEST   9
`define CIE_BIT_BANK   8

// Access bank split and its upper bank
`define CIE_ACC_SPLIT  8'h80
`define CIE_SFR_BANK   4'hf

// Program counter step per instruction word
`define CIE_PC_STEP    21'h000002

`endif

/* File: cie_core.sv */
// Instruction execute core with AHB-Lite register access.
// Assumes an asynchronous-read program memory on progAddr/progData,
// on the same clock, with data valid within one cycle of the address.
//
// Summary of operation
// RULE1 - destination bit picks accumulator or file
// RULE2 - bank bit picks access bank or pointer
// RULE3 - add accumulator, carry and file; five flags
// RULE4 - and literal into accumulator; n, z
// RULE5 - invert one file bit; flags kept
// RULE6 - on overflow branch pc+2+2n, idle cycle
// RULE7 - far jump: two words, two cycles
// RULE8 - increment file, routed, five flags
// RULE9 - file minus accumulator minus borrow; five flags
// RULE10 - swap file nibbles, routed, flags kept
// RULE11 - four phases: decode, read, process, write
`timescale 1ns/1ps
`include "cie_cfg.svh"
module cie_core #(
  parameter int MEM_AW = 9
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  // Program memory
  output logic [19:0]       progAddr,
  input  wire logic [15:0]  progData
);
  import cie_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic cie_op_t decode(input logic [15:0] ins);
    if (ins[15:10] == `CIE_OPC_ADDC) decode = OP_ADDC;
    else if (ins[15:8] == `CIE_OPC_ANDL) decode = OP_ANDL;
    else if (ins[15:12] == `CIE_OPC_TOGL) decode = OP_TOGL;
    else if (ins[15:8] == `CIE_OPC_BOV) decode = OP_BOV;
    else if (ins[15:8] == `CIE_OPC_JMP1) decode = OP_JMP;
    else if (ins[15:10] == `CIE_OPC_INCREMENT_FILE_OP) decode = OP_INCREMENT_FILE_OP;
    else if (ins[15:10] == `CIE_OPC_SUBB) decode = OP_SUBB;
    else if (ins[15:10] == `CIE_OPC_SWAP) decode = OP_SWAP;
    else decode = OP_NOP;
  endfunction

  // RULE2 bank select
  function automatic logic [11:0] fileAddr(input logic [15:0] ins, input logic [3:0] bank);
    if (ins[`CIE_BIT_BANK]) fileAddr = {bank, ins[7:0]};
    else if (ins[7:0] < `CIE_ACC_SPLIT) fileAddr = {4'h0, ins[7:0]};
    else fileAddr = {`CIE_SFR_BANK, ins[7:0]};
  endfunction

  // RULE1 destination select
  function automatic logic destIsAcc(input cie_op_t op, input logic [15:0] ins);
    unique case (op)
      OP_ADDC, OP_INCREMENT_FILE_OP, OP_SUBB, OP_SWAP: destIsAcc = !ins[`CIE_BIT_DEST];
      OP_ANDL: destIsAcc = 1'b1;
      default: destIsAcc = 1'b0;
    endcase
  endfunction

  // Instructions that may write the file
  function automatic logic writesFile(input cie_op_t op);
    writesFile = op inside {OP_ADDC, OP_INCREMENT_FILE_OP, OP_SUBB, OP_SWAP, OP_TOGL};
  endfunction

  // RULE6 taken branch target
  function automatic logic [20:0] branchTarget(
    input logic [20:0] pc,
    input logic [7:0]  ofs
  );
    branchTarget = pc + `CIE_PC_STEP + {{12{ofs[7]}}, ofs, 1'b0};
  endfunction

  // RULE7 far jump target
  function automatic logic [20:0] jumpTarget(
    input logic [11:0] hi,
    input logic [7:0]  lo
  );
    jumpTarget = {hi, lo, 1'b0};
  endfunction

  // Flags written only where the instruction updates them
  function automatic cie_flags_t mergeFlags(
    input cie_flags_t old,
    input cie_flags_t val,
    input cie_flags_t upd
  );
    mergeFlags = (old & ~upd) | (val & upd);
  endfunction

  // Register view for bus reads; unmapped offsets read zero
  function automatic logic [31:0] regView(
    input logic [11:0] ofs,
    input logic        run,
    input cie_flags_t  stat,
    input logic [7:0]  acc,
    input logic [3:0]  bank,
    input logic [20:0] pc,
    input cie_phase_t  phase,
    input logic [15:0] ins
  );
    unique case (ofs)
      `CIE_OFS_CTRL:   regView = {31'h0, run};
      `CIE_OFS_STATUS: regView = {27'h0, stat};
      `CIE_OFS_ACC:    regView = {24'h0, acc};
      `CIE_OFS_BANK:   regView = {28'h0, bank};
      `CIE_OFS_PC:     regView = {11'h0, pc};
      `CIE_OFS_INSTR:  regView = {14'h0, phase, ins};
      default:         regView = 32'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State

  cie_phase_t   phase_r,   phase_nxt;
  cie_op_t      op_r,      op_nxt;
  logic [15:0]  ir_r,      ir_nxt;
  logic [7:0]   opnd_r,    opnd_nxt;
  logic [7:0]   res_r,     res_nxt;
  cie_flags_t   flg_r,     flg_nxt;
  cie_flags_t   upd_r,     upd_nxt;
  cie_flags_t   stat_r,    stat_nxt;
  logic [7:0]   acc_r,     acc_nxt;
  logic [3:0]   bsr_r,     bsr_nxt;
  logic [20:0]  pc_r,      pc_nxt;
  logic [7:0]   jmpLo_r,   jmpLo_nxt;
  logic         second_r,  second_nxt;
  logic         idle_r,    idle_nxt;
  logic         run_r,     run_nxt;
  cie_ahb_req_t req_r,     req_nxt;
  logic [31:0]  rdata_r,   rdata_nxt;

  cie_mem_wr_t  memWr;
  logic [7:0]   memRd;
  logic [7:0]   aluRes;
  cie_flags_t   aluFlg;
  cie_flags_t   aluUpd;
  logic         busWe;
  logic         destAcc;

  ////////////////////////////////////////////////////////////////////
  // Datapath

  cie_alu u_alu (
    .op      (op_r),
    .accVal  (acc_r),
    .fileVal (opnd_r),
    .carryIn (stat_r.c),
    .bitSel  (ir_r[11:9]),
    .literal (ir_r[7:0]),
    .flags   (aluFlg),
    .upd     (aluUpd),
    .result  (aluRes)
  );

  cie_data_mem #(
    .AW (MEM_AW)
  ) u_mem (
    .clk    (clk),
    .reset  (reset),
    .rdAddr (fileAddr(ir_r, bsr_r)),
    .wr     (memWr),
    .rdData (memRd)
  );

  ////////////////////////////////////////////////////////////////////
  // Instruction sequencing and register writes

  assign busWe = req_r.sel && req_r.write;

  always_comb begin
    phase_nxt  = phase_r;
    op_nxt     = op_r;
    ir_nxt     = ir_r;
    opnd_nxt   = opnd_r;
    res_nxt    = res_r;
    flg_nxt    = flg_r;
    upd_nxt    = upd_r;
    stat_nxt   = stat_r;
    acc_nxt    = acc_r;
    bsr_nxt    = bsr_r;
    pc_nxt     = pc_r;
    jmpLo_nxt  = jmpLo_r;
    second_nxt = second_r;
    idle_nxt   = idle_r;
    run_nxt    = run_r;
    memWr      = '0;
    destAcc    = 1'b0;
    if (run_r) begin
      unique case (phase_r)
        // RULE11 decode phase
        PH_Q1: begin
          phase_nxt = PH_Q2;
          ir_nxt    = progData;
          if (idle_r) begin
            op_nxt = OP_NOP;
          end else if (second_r) begin
            op_nxt = (progData[15:12] == `CIE_OPC_JMP2) ? OP_JMP : OP_NOP;
          end else begin
            op_nxt = decode(progData);
          end
        end
        // RULE11 read operand
        PH_Q2: begin
          phase_nxt = PH_Q3;
          opnd_nxt  = memRd;
          // RULE7 low literal byte
          if (op_r == OP_JMP && !second_r) begin
            jmpLo_nxt = ir_r[7:0];
          end
        end
        // RULE11 process data
        PH_Q3: begin
          phase_nxt = PH_Q4;
          res_nxt   = aluRes;
          flg_nxt   = aluFlg;
          upd_nxt   = aluUpd;
        end
        // RULE11 write destination
        PH_Q4: begin
          phase_nxt = PH_Q1;
          stat_nxt  = mergeFlags(stat_r, flg_r, upd_r);
          // RULE1 destination select
          destAcc   = destIsAcc(op_r, ir_r);
          if (destAcc) begin
            acc_nxt = res_r;
          end else if (writesFile(op_r)) begin
            memWr.we   = 1'b1;
            memWr.addr = fileAddr(ir_r, bsr_r);
            memWr.data = res_r;
          end
          if (idle_r) begin
            idle_nxt = 1'b0;
          // RULE6 taken branch
          end else if (op_r == OP_BOV && stat_r.ov) begin
            pc_nxt   = branchTarget(pc_r, ir_r[7:0]);
            idle_nxt = 1'b1;
          // RULE7 load pc
          end else if (op_r == OP_JMP && second_r) begin
            pc_nxt     = jumpTarget(ir_r[11:0], jmpLo_r);
            second_nxt = 1'b0;
          end else begin
            pc_nxt     = pc_r + `CIE_PC_STEP;
            second_nxt = (op_r == OP_JMP) && !second_r;
          end
        end
      endcase
    end
    if (busWe && req_r.addr == `CIE_OFS_CTRL) begin
      run_nxt = hwdata[0];
    end
    if (busWe && !run_r) begin
      unique case (req_r.addr)
        `CIE_OFS_STATUS: stat_nxt = hwdata[4:0];
        `CIE_OFS_ACC:    acc_nxt  = hwdata[7:0];
        `CIE_OFS_BANK:   bsr_nxt  = hwdata[3:0];
        `CIE_OFS_PC: begin
          pc_nxt     = {hwdata[20:1], 1'b0};
          phase_nxt  = PH_Q1;
          second_nxt = 1'b0;
          idle_nxt   = 1'b0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_r  <= PH_Q1;
      op_r     <= OP_NOP;
      ir_r     <= 16'h0000;
      opnd_r   <= 8'h00;
      res_r    <= 8'h00;
      flg_r    <= `CIE_RST_FLAGS;
      upd_r    <= `CIE_RST_FLAGS;
      stat_r   <= `CIE_RST_FLAGS;
      acc_r    <= `CIE_RST_ACC;
      bsr_r    <= `CIE_RST_BANK;
      pc_r     <= `CIE_RST_PC;
      jmpLo_r  <= 8'h00;
      second_r <= 1'b0;
      idle_r   <= 1'b0;
      run_r    <= `CIE_RST_CTRL;
    end else begin
      phase_r  <= phase_nxt;
      op_r     <= op_nxt;
      ir_r     <= ir_nxt;
      opnd_r   <= opnd_nxt;
      res_r    <= res_nxt;
      flg_r    <= flg_nxt;
      upd_r    <= upd_nxt;
      stat_r   <= stat_nxt;
      acc_r    <= acc_nxt;
      bsr_r    <= bsr_nxt;
      pc_r     <= pc_nxt;
      jmpLo_r  <= jmpLo_nxt;
      second_r <= second_nxt;
      idle_r   <= idle_nxt;
      run_r    <= run_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase capture and read data

  always_comb begin
    req_nxt   = req_r;
    rdata_nxt = rdata_r;
    if (hready) begin
      req_nxt.sel   = hsel && htrans[1];
      req_nxt.write = hwrite;
      req_nxt.addr  = haddr[11:0];
      if (hsel && htrans[1] && !hwrite) begin
        rdata_nxt = regView(haddr[11:0], run_nxt, stat_nxt, acc_nxt, bsr_nxt, pc_nxt, phase_nxt, ir_nxt);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      req_r     <= '0;
      rdata_r   <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      progAddr  <= 20'h00000;
    end else begin
      req_r     <= req_nxt;
      rdata_r   <= rdata_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      progAddr  <= pc_nxt[20:1];
    end
  end

  assign hrdata = rdata_r;

endmodule

/* File: cie_core_sva.sv */
// Checker for the instruction execute core.
// Assumes a bind onto cie_core; sees its ports only.
`timescale 1ns/1ps
`include "cie_cfg.svh"
module cie_core_sva #(
  parameter int MEM_AW = 9
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Program memory
  input wire logic [19:0] progAddr,
  input wire logic [15:0] progData
);
  import cie_pkg::*;
  logic        rdTake;
  logic [11:0] ofs;
  assign rdTake = hsel && hready && htrans[1] && !hwrite;
  assign ofs    = haddr[11:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////////
  chk_resp_okay: assert property (rdTake |=> hresp == 1'b0)
    else $error("response not okay");
  chk_ready_high: assert property (hsel && htrans[1] |=> hreadyout == 1'b1)
    else $error("wait state inserted");
  chk_addr_steady: assert property ($changed(progAddr) |=> $stable(progAddr)[*3])
    else $error("instruction cycle shorter than four clocks");
  chk_jump_holds: assert property ($changed(progAddr) && progData[15:8] == 8'hef
    |=> $stable(progAddr)[*3] ##1 ($stable(progAddr) || progAddr == $past(progAddr) + 20'h1))
    else $error("far jump shorter than two cycles");
  chk_unmapped_zero: assert property (rdTake && ofs > `CIE_OFS_INSTR |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!rdTake |=> $stable(hrdata))
    else $error("read data changed without a read");
  chk_status_width: assert property (rdTake && ofs == `CIE_OFS_STATUS |=> hrdata[31:5] == 27'h0)
    else $error("status upper bits set");
  chk_acc_width: assert property (rdTake && ofs == `CIE_OFS_ACC |=> hrdata[31:8] == 24'h0)
    else $error("accumulator upper bits set");
  chk_pc_even: assert property (rdTake && ofs == `CIE_OFS_PC
    |=> hrdata[0] == 1'b0 && hrdata[31:21] == 11'h0)
    else $error("program counter malformed");
  chk_bank_width: assert property (rdTake && ofs == `CIE_OFS_BANK |=> hrdata[31:4] == 28'h0)
    else $error("bank upper bits set");
endmodule

bind cie_core cie_core_sva #(.MEM_AW(MEM_AW)) cie_core_sva_inst (
  .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .progAddr(progAddr), .progData(progData)
);

/* File: cie_core_tb_top.sv */
// Testbench for the instruction execute core.
// Assumes cie_cfg.svh on the include path and the checker bound.
`timescale 1ns/1ps
`include "cie_cfg.svh"
module cie_core_tb_top;
  import cie_pkg::*;
  logic        clk, reset, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [19:0] progAddr;
  logic [15:0] progData;
  logic [15:0] prog [0:63];
  int          num_errors, cmp_count;
  assign hready   = hreadyout;
  assign progData = prog[progAddr[5:0]];

  cie_core #(.MEM_AW(9)) cie_core_inst (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .progAddr(progAddr), .progData(progData)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    xfer(1'b0, a, 32'h0, rd);
    cmp_count++;
    if (rd !== exp) begin
      num_errors++;
      $display("unexpected at %0t: addr %h read %h want %h", $time, a, rd, exp);
    end
  endtask

  // Start at word w, let n clocks run
  task automatic run(input logic [11:0] w, input int n);
    wr(`CIE_OFS_PC, {19'h0, w, 1'b0});
    wr(`CIE_OFS_CTRL, 32'h1);
    repeat (n) @(posedge clk);
  endtask

  task automatic halt;
    wr(`CIE_OFS_CTRL, 32'h0);
    repeat (8) @(posedge clk);
  endtask

  // Two-word far jump at word i
  task automatic setj(input int i, input logic [19:0] k);
    prog[i]     = {8'hef, k[7:0]};
    prog[i + 1] = {4'hf, k[19:8]};
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out;
  end

  initial begin
    logic [11:0] regs [6];
    regs = '{`CIE_OFS_CTRL, `CIE_OFS_STATUS, `CIE_OFS_ACC, `CIE_OFS_BANK, `CIE_OFS_PC, `CIE_OFS_INSTR};
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    num_errors = 0;
    cmp_count = 0;
    foreach (prog[i]) prog[i] = 16'h0000;
    prog[0] = 16'h0b5f;
    setj(1, 20'h1);
    prog[3] = 16'h2310;
    prog[4] = 16'h3810;
    prog[5] = 16'h3910;
    setj(6, 20'h6);
    prog[8] = 16'h2220;
    prog[9] = 16'h7e20;
    prog[10] = 16'h2a20;
    prog[11] = 16'h3820;
    setj(12, 20'hc);
    prog[14] = 16'h5840;
    prog[15] = 16'h5840;
    setj(16, 20'h10);
    prog[18] = 16'he402;
    prog[19] = 16'h0b00;
    prog[20] = 16'h0b00;
    prog[21] = 16'h0b0f;
    setj(22, 20'h16);
    setj(24, 20'h123);
    setj(35, 20'h123);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (regs[i]) rdchk(regs[i], 32'h0);
    wr(12'h018, 32'hffffffff);
    rdchk(12'h018, 32'h0);
    // And literal; accumulator write refused while running
    wr(`CIE_OFS_ACC, 32'ha3);
    wr(`CIE_OFS_STATUS, 32'h0b);
    run(0, 24);
    wr(`CIE_OFS_ACC, 32'h77);
    halt;
    rdchk(`CIE_OFS_ACC, 32'h03);
    rdchk(`CIE_OFS_STATUS, 32'h0b);
    // Add with carry into bank 1, swaps from both banks
    wr(`CIE_OFS_ACC, 32'h35);
    wr(`CIE_OFS_STATUS, 32'h01);
    wr(`CIE_OFS_BANK, 32'h1);
    run(3, 28);
    halt;
    rdchk(`CIE_OFS_ACC, 32'h63);
    rdchk(`CIE_OFS_STATUS, 32'h00);
    // Toggle bit 7, increment across sign boundary
    wr(`CIE_OFS_ACC, 32'hfe);
    wr(`CIE_OFS_STATUS, 32'h01);
    run(8, 32);
    halt;
    rdchk(`CIE_OFS_ACC, 32'h08);
    rdchk(`CIE_OFS_STATUS, 32'h1a);
    // Subtract twice, second with borrow pending
    wr(`CIE_OFS_ACC, 32'h0e);
    wr(`CIE_OFS_STATUS, 32'h01);
    run(14, 24);
    halt;
    rdchk(`CIE_OFS_ACC, 32'h0d);
    rdchk(`CIE_OFS_STATUS, 32'h00);
    // Branch on overflow, not taken then taken
    for (int ov = 0; ov < 2; ov++) begin
      wr(`CIE_OFS_ACC, 32'hff);
      wr(`CIE_OFS_STATUS, (ov != 0) ? 32'h08 : 32'h00);
      run(18, 36);
      halt;
      rdchk(`CIE_OFS_ACC, (ov != 0) ? 32'h0f : 32'h00);
      rdchk(`CIE_OFS_STATUS, (ov != 0) ? 32'h08 : 32'h04);
    end
    // Far jump with upper literal bits
    run(24, 24);
    halt;
    rdchk(`CIE_OFS_PC, 32'h246);
    close_out;
  end
endmodule

/* File: cie_data_mem.sv */
// Data memory of flip-flops with one write port and a combinational read.
// Assumes addresses above the storage size alias onto it.
`timescale 1ns/1ps
module cie_data_mem #(
  parameter int AW = 9
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Access
  input  wire logic [11:0]         rdAddr,
  input  wire cie_pkg::cie_mem_wr_t wr,
  output logic [7:0]               rdData
);
  import cie_pkg::*;

  logic [7:0] mem_r [2**AW];

  assign rdData = mem_r[rdAddr[AW-1:0]];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (wr.we) begin
      mem_r[wr.addr[AW-1:0]] <= wr.data;
    end
  end

endmodule

/* File: cie_pkg.sv */
// Types shared by the instruction execute block.
// Assumes cie_cfg.svh is on the include path.
package cie_pkg;

  typedef enum logic [3:0] {
    OP_NOP, OP_ADDC, OP_ANDL, OP_TOGL, OP_BOV,
    OP_JMP, OP_INCREMENT_FILE_OP, OP_SUBB, OP_SWAP
  } cie_op_t;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} cie_phase_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } cie_flags_t;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
  } cie_ahb_req_t;

  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  data;
  } cie_mem_wr_t;

endpackage
